/* File: include/ssp_pkg.sv */
// Constants and types for the serial programming register block
package ssp_pkg;
  // Serial word width and field widths
  localparam int WORD_W = 24;
  localparam int REF_RATIO_W = 11;
  localparam int SWALLOW_W = 7;
  localparam int MAIN_RATIO_W = 11;
  localparam int CUR_W = 2;
  // Field positions, zero-based (word bit n sits at index n-1)
  localparam int POS_ADDR_LOW = 0;
  localparam int POS_REF_RATIO = 1;
  localparam int POS_RELOAD = 12;
  localparam int POS_PUMP_OFF = 13;
  localparam int POS_BAND2_CUR = 14;
  localparam int POS_SLOPE = 16;
  localparam int POS_BAND1_CUR = 17;
  localparam int POS_INIT = 19;
  localparam int POS_RES_SEL = 20;
  localparam int POS_SETUP_EN = 21;
  localparam int POS_LOCK_EN = 22;
  localparam int POS_SWALLOW = 1;
  localparam int POS_MAIN_RATIO = 8;
  localparam int POS_CHAN_EN = 21;
  localparam int POS_BAND = 22;
  localparam int POS_ADDR_HIGH = 23;
  // Lock qualification: consecutive short comparison periods
  localparam logic [3:0] LOCK_COUNT = 4'hF;
  // Reset values
  localparam logic [WORD_W-1:0] SHIFT_RST = 24'h000000;
  localparam logic [REF_RATIO_W-1:0] REF_RATIO_RST = 11'h000;
  localparam logic [SWALLOW_W-1:0] SWALLOW_RST = 7'h00;
  localparam logic [MAIN_RATIO_W-1:0] MAIN_RATIO_RST = 11'h000;
  localparam logic [CUR_W-1:0] CUR_RST = 2'h0;
  // Pump current codes, field read as {higher bit, lower bit}
  localparam logic [CUR_W-1:0] CUR_0P7_MA = 2'h0;
  localparam logic [CUR_W-1:0] CUR_0P9_MA = 2'h1;
  localparam logic [CUR_W-1:0] CUR_1P9_MA = 2'h2;
  localparam logic [CUR_W-1:0] CUR_2P5_MA = 2'h3;
  // Address pair {word bit 24, word bit 1}
  typedef enum logic [1:0] {
    SSP_TGT_CHAN = 2'b00,
    SSP_TGT_SETUP = 2'b01,
    SSP_TGT_SEC_A = 2'b10,
    SSP_TGT_SEC_B = 2'b11
  } ssp_tgt_t;
endpackage

/* File: src/ssp_regs.sv */
// Serial programming front end and control registers of the synthesizer
`timescale 1ns/10ps
module ssp_regs (
  // Core clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Three-wire serial bus from the host
  input wire logic ser_clk,
  input wire logic serial_data_in,
  input wire logic load_strobe,
  // Powerdown pin, low means sleep
  input wire logic sleep_pin_n,
  // Lock detector inputs from the phase comparator
  input wire logic compare_tick,
  input wire logic pump_pulse_long,
  // Reference counter controls
  output logic [ssp_pkg::REF_RATIO_W-1:0] ref_ratio,
  output logic reload_mode,
  output logic counter_reload_now,
  // Channel counter controls
  output logic [ssp_pkg::SWALLOW_W-1:0] swallow_count,
  output logic [ssp_pkg::MAIN_RATIO_W-1:0] main_ratio,
  output logic band_select,
  // Charge pump and detector controls
  output logic pump_off,
  output logic [ssp_pkg::CUR_W-1:0] pump_current,
  output logic detector_slope,
  output logic resistor_select,
  // Power and lock status
  output logic init_reset,
  output logic synth_enable,
  output logic lock_indicator_pin
);
  import ssp_pkg::*;

  // Serial clock domain
  logic [WORD_W-1:0] shift_reg; // Holding shifter, newest bit at index 0

  // Synchronisers, two stages each; strobe and tick add an edge history bit
  logic strobe_s1_reg, strobe_s2_reg, strobe_s3_reg;
  logic sleep_s1_reg, sleep_s2_reg;
  logic tick_s1_reg, tick_s2_reg, tick_s3_reg;
  logic long_s1_reg, long_s2_reg;

  // Setup register fields
  logic [REF_RATIO_W-1:0] ref_ratio_reg;
  logic reload_mode_reg;
  logic pump_off_reg;
  logic [CUR_W-1:0] band2_cur_reg;
  logic detector_slope_reg;
  logic [CUR_W-1:0] band1_cur_reg;
  logic init_reset_reg; // Self-clearing, high one cycle
  logic resistor_select_reg;
  logic setup_word_enable_reg;
  logic lock_indicator_enable_reg;

  // Channel register fields
  logic [SWALLOW_W-1:0] swallow_reg;
  logic [MAIN_RATIO_W-1:0] main_ratio_reg;
  logic channel_word_enable_reg;
  logic band_reg;

  // Derived state
  logic eff_enable_reg; // Enable bit of the latest write
  logic reload_now_reg; // Forced reload pulse
  logic synth_enable_reg;
  logic [CUR_W-1:0] pump_current_reg;
  logic [3:0] lock_cnt_reg;
  logic lock_pin_reg;

  // Decode wires
  logic strobe_rise;
  logic tick_rise;
  ssp_tgt_t tgt;
  logic wr_setup;
  logic wr_chan;
  logic init_req;

  // Shift one bit per rising serial clock; the oldest bit falls out, so
  // the last 24 bits before the strobe form the word
  always_ff @(posedge ser_clk or negedge rst_b) begin
    if (!rst_b) begin
      shift_reg <= SHIFT_RST;
    end else begin
      shift_reg <= {shift_reg[WORD_W-2:0], serial_data_in};
    end
  end

  // Pin synchronisers; only the second stage and the history bits are read by logic
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_s1_reg <= 1'b0;
      strobe_s2_reg <= 1'b0;
      strobe_s3_reg <= 1'b0;
      sleep_s1_reg <= 1'b0;
      sleep_s2_reg <= 1'b0;
      tick_s1_reg <= 1'b0;
      tick_s2_reg <= 1'b0;
      tick_s3_reg <= 1'b0;
      long_s1_reg <= 1'b0;
      long_s2_reg <= 1'b0;
    end else begin
      strobe_s1_reg <= load_strobe;
      strobe_s2_reg <= strobe_s1_reg;
      strobe_s3_reg <= strobe_s2_reg;
      sleep_s1_reg <= sleep_pin_n;
      sleep_s2_reg <= sleep_s1_reg;
      tick_s1_reg <= compare_tick;
      tick_s2_reg <= tick_s1_reg;
      tick_s3_reg <= tick_s2_reg;
      long_s1_reg <= pump_pulse_long;
      long_s2_reg <= long_s1_reg;
    end
  end

  // Strobe rise marks a complete word; the shifter is quiet then because
  // the serial clock is held low, so it is read whole in this domain
  assign strobe_rise = strobe_s2_reg & ~strobe_s3_reg;
  assign tick_rise = tick_s2_reg & ~tick_s3_reg;
  // Address pair from the first and last bits shifted
  assign tgt = ssp_tgt_t'({shift_reg[POS_ADDR_HIGH],
                           shift_reg[POS_ADDR_LOW]});
  // Secondary patterns decode to neither write
  assign wr_setup = strobe_rise && (tgt == SSP_TGT_SETUP);
  assign wr_chan = strobe_rise && (tgt == SSP_TGT_CHAN);
  assign init_req = wr_setup && shift_reg[POS_INIT];

  // Setup register: every field moves together on one strobe
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ref_ratio_reg <= REF_RATIO_RST;
      reload_mode_reg <= 1'b0;
      pump_off_reg <= 1'b0;
      band2_cur_reg <= CUR_RST;
      detector_slope_reg <= 1'b0;
      band1_cur_reg <= CUR_RST;
      resistor_select_reg <= 1'b0;
      lock_indicator_enable_reg <= 1'b0;
    end else if (wr_setup) begin
      ref_ratio_reg <= shift_reg[POS_REF_RATIO +: REF_RATIO_W];
      reload_mode_reg <= shift_reg[POS_RELOAD];
      pump_off_reg <= shift_reg[POS_PUMP_OFF];
      band2_cur_reg <= shift_reg[POS_BAND2_CUR +: CUR_W];
      detector_slope_reg <= shift_reg[POS_SLOPE];
      band1_cur_reg <= shift_reg[POS_BAND1_CUR +: CUR_W];
      resistor_select_reg <= shift_reg[POS_RES_SEL];
      lock_indicator_enable_reg <= shift_reg[POS_LOCK_EN];
    end
  end

  // Init reset is never stored as a level: it pulses for one cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      init_reset_reg <= 1'b0;
    end else begin
      init_reset_reg <= init_req;
    end
  end

  // Counter ratios of the channel word; init reset keeps them so the
  // counters carry on with their previous values
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      swallow_reg <= SWALLOW_RST;
      main_ratio_reg <= MAIN_RATIO_RST;
    end else if (wr_chan) begin
      swallow_reg <= shift_reg[POS_SWALLOW +: SWALLOW_W];
      main_ratio_reg <= shift_reg[POS_MAIN_RATIO +: MAIN_RATIO_W];
    end
  end

  // Channel control bits; init reset clears them, bit 21 is ignored
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      channel_word_enable_reg <= 1'b0;
      band_reg <= 1'b0;
    end else if (init_req) begin
      channel_word_enable_reg <= 1'b0;
      band_reg <= 1'b0;
    end else if (wr_chan) begin
      channel_word_enable_reg <= shift_reg[POS_CHAN_EN];
      band_reg <= shift_reg[POS_BAND];
    end
  end

  // Setup enable bit; an init write forces it low whatever was sent
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      setup_word_enable_reg <= 1'b0;
    end else if (wr_setup) begin
      setup_word_enable_reg <= shift_reg[POS_SETUP_EN] & ~init_req;
    end
  end

  // Effective enable follows whichever register was written last
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      eff_enable_reg <= 1'b0;
    end else if (wr_setup) begin
      eff_enable_reg <= shift_reg[POS_SETUP_EN] & ~init_req;
    end else if (wr_chan) begin
      eff_enable_reg <= shift_reg[POS_CHAN_EN];
    end
  end

  // Forced reload pulse when the latch lands in reload mode; in the
  // other mode the counters pick up new values at their own zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reload_now_reg <= 1'b0;
    end else begin
      reload_now_reg <= (wr_setup && shift_reg[POS_RELOAD]) ||
                        (wr_chan && reload_mode_reg);
    end
  end

  // Pin and effective enable combine; nothing is cleared while asleep,
  // so the programmed state survives powerdown
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      synth_enable_reg <= 1'b0;
    end else begin
      synth_enable_reg <= sleep_s2_reg & eff_enable_reg;
    end
  end

  // Pump current follows the band bit; codes pass through unchanged
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pump_current_reg <= CUR_0P7_MA;
    end else begin
      pump_current_reg <= band_reg ? band2_cur_reg : band1_cur_reg;
    end
  end

  // Lock qualifier: long pulses clear at once, short periods count up
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_cnt_reg <= 4'h0;
    end else if (long_s2_reg) begin
      lock_cnt_reg <= 4'h0;
    end else if (tick_rise && lock_cnt_reg != LOCK_COUNT) begin
      lock_cnt_reg <= lock_cnt_reg + 4'h1;
    end
  end

  // Lock output stays high when the indicator is disabled
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_pin_reg <= 1'b1;
    end else begin
      lock_pin_reg <= ~lock_indicator_enable_reg |
                      (lock_cnt_reg == LOCK_COUNT);
    end
  end

  // Outputs, all from flip-flops
  assign ref_ratio = ref_ratio_reg;
  assign reload_mode = reload_mode_reg;
  assign counter_reload_now = reload_now_reg;
  assign swallow_count = swallow_reg;
  assign main_ratio = main_ratio_reg;
  assign band_select = band_reg;
  assign pump_off = pump_off_reg;
  assign pump_current = pump_current_reg;
  assign detector_slope = detector_slope_reg;
  assign resistor_select = resistor_select_reg;
  assign init_reset = init_reset_reg;
  assign synth_enable = synth_enable_reg;
  assign lock_indicator_pin = lock_pin_reg;

  // Checks, all in the core clock domain
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  sequence s_setup_write;
    wr_setup;
  endsequence

  sequence s_init_write;
    init_req;
  endsequence

  property p_setup_capture;
    s_setup_write |=> ref_ratio ==
      $past(shift_reg[POS_REF_RATIO +: REF_RATIO_W]);
  endproperty
  a_setup_capture: assert property (p_setup_capture)
    else $error("setup ratio not captured from word");

  property p_secondary_ignored;
    (strobe_rise && shift_reg[POS_ADDR_HIGH]) |=>
      $stable(ref_ratio) && $stable(main_ratio) && $stable(band_select);
  endproperty
  a_secondary_ignored: assert property (p_secondary_ignored)
    else $error("secondary word changed a register");

  property p_init_pulse;
    s_init_write |=> init_reset ##1 !init_reset;
  endproperty
  a_init_pulse: assert property (p_init_pulse)
    else $error("init reset did not pulse one cycle");

  property p_init_powerdown;
    s_init_write |=> !eff_enable_reg ##1 !synth_enable;
  endproperty
  a_init_powerdown: assert property (p_init_powerdown)
    else $error("init reset did not force powerdown");

  property p_chan_enable;
    wr_chan |=> eff_enable_reg == $past(shift_reg[POS_CHAN_EN]);
  endproperty
  a_chan_enable: assert property (p_chan_enable)
    else $error("channel write did not set effective enable");

  property p_sleep_pin;
    !sleep_s2_reg |=> !synth_enable;
  endproperty
  a_sleep_pin: assert property (p_sleep_pin)
    else $error("enabled while powerdown pin low");

  property p_forced_reload;
    (wr_setup && shift_reg[POS_RELOAD]) |=> counter_reload_now;
  endproperty
  a_forced_reload: assert property (p_forced_reload)
    else $error("forced reload pulse missing");

  property p_band_current;
    ##1 band_reg |=> pump_current == $past(band2_cur_reg);
  endproperty
  a_band_current: assert property (p_band_current)
    else $error("band 2 current not selected");

  property p_band1_current;
    ##1 !band_reg |=> pump_current == $past(band1_cur_reg);
  endproperty
  a_band1_current: assert property (p_band1_current)
    else $error("band 1 current not selected");

  property p_lock_disabled;
    !lock_indicator_enable_reg |=> lock_indicator_pin;
  endproperty
  a_lock_disabled: assert property (p_lock_disabled)
    else $error("lock pin low while indicator disabled");

  property p_lock_drop;
    (long_s2_reg && lock_indicator_enable_reg) |=> ##1
      (!lock_indicator_pin || !lock_indicator_enable_reg);
  endproperty
  a_lock_drop: assert property (p_lock_drop)
    else $error("lock pin did not drop on long pulse");

endmodule

/* File: verification/ssp_host_model.sv */
// Host controller model driving the three-wire programming bus
`timescale 1ns/10ps
module ssp_host_model (
  // Three-wire bus toward the device
  output logic ser_clk,
  output logic serial_data_in,
  output logic load_strobe
);
  import ssp_pkg::*;
  // Bus idles with clock and strobe low
  initial begin
    ser_clk = 1'b0;
    serial_data_in = 1'b0;
    load_strobe = 1'b0;
  end
  // Whole word, bit 24 first; the clock runs only inside a frame
  task automatic send_word(input logic [WORD_W-1:0] w);
    #7;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      serial_data_in = w[i];
      #35 ser_clk = 1'b1;
      #40 ser_clk = 1'b0;
      #5;
    end
    // Hold time over: show the inverse so a stale bit cannot pass
    serial_data_in = ~w[0];
    // Strobe rises only with the clock low
    #35 load_strobe = 1'b1;
    #100 load_strobe = 1'b0;
    // Clock stays still while the shifter is read
    #100;
  endtask
endmodule

/* File: verification/ssp_regs_test.sv */
// Self-checking bench for the serial programming register block
`timescale 1ns/10ps
module ssp_regs_test;
  import ssp_pkg::*;
  // One programming step: word, pin level, expected enable
  typedef struct packed {
    logic [WORD_W-1:0] word;
    logic sleep_n;
    logic en;
  } ssp_row_t;
  // Clock, reset and side inputs
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic sleep_pin_n = 1'b1;
  logic compare_tick = 1'b0;
  logic pump_pulse_long = 1'b0;
  // Serial bus from the host model
  logic ser_clk, serial_data_in, load_strobe;
  // Design outputs
  logic [REF_RATIO_W-1:0] ref_ratio;
  logic [SWALLOW_W-1:0] swallow_count;
  logic [MAIN_RATIO_W-1:0] main_ratio;
  logic [CUR_W-1:0] pump_current;
  logic reload_mode, counter_reload_now, band_select, pump_off;
  logic detector_slope, resistor_select, init_reset, synth_enable;
  logic lock_indicator_pin;
  // Sticky catchers, since the pulses last one cycle
  logic rl_seen = 1'b0;
  logic in_seen = 1'b0;
  // Predicted state
  logic [WORD_W-1:0] sw;
  logic [SWALLOW_W-1:0] e_sw;
  logic [MAIN_RATIO_W-1:0] e_main;
  logic e_band, e_en, e_lock;
  int miscompares = 0;
  int n_tests = 0;
  ssp_row_t rows [11];
  wire [37:0] got = {ref_ratio, reload_mode, pump_off, detector_slope,
    resistor_select, swallow_count, main_ratio, band_select, pump_current,
    synth_enable, lock_indicator_pin};

  // Core clock, 25 ns period
  always #12.5 ref_clk = ~ref_clk;

  // Catch one-cycle pulses
  always @(posedge ref_clk) begin
    if (counter_reload_now === 1'b1)
      rl_seen <= 1'b1;
    if (init_reset === 1'b1)
      in_seen <= 1'b1;
  end

  ssp_host_model ssp_host_model_inst (
    .ser_clk(ser_clk),
    .serial_data_in(serial_data_in),
    .load_strobe(load_strobe)
  );

  ssp_regs ssp_regs_inst (
    .ref_clk(ref_clk), .rst_b(rst_b), .ser_clk(ser_clk),
    .serial_data_in(serial_data_in), .load_strobe(load_strobe),
    .sleep_pin_n(sleep_pin_n), .compare_tick(compare_tick),
    .pump_pulse_long(pump_pulse_long), .ref_ratio(ref_ratio),
    .reload_mode(reload_mode), .counter_reload_now(counter_reload_now),
    .swallow_count(swallow_count), .main_ratio(main_ratio),
    .band_select(band_select), .pump_off(pump_off),
    .pump_current(pump_current), .detector_slope(detector_slope),
    .resistor_select(resistor_select), .init_reset(init_reset),
    .synth_enable(synth_enable), .lock_indicator_pin(lock_indicator_pin)
  );

  // Setup word: {lock,en,res,init,band1,slope,band2,off,reload}, ratio
  function automatic logic [23:0] sw_w(logic [10:0] f, logic [10:0] r);
    return {1'b0, f, r, 1'b1};
  endfunction
  // Channel word; bits 20 and 21 set to show they are ignored
  function automatic logic [23:0] cw_w(logic b, logic en, logic [10:0] m,
      logic [6:0] a);
    return {1'b0, b, en, 2'b11, m, a, 1'b0};
  endfunction
  // Expected port picture from the predicted state
  function automatic logic [37:0] pred();
    return {sw[11:1], sw[12], sw[13], sw[16], sw[20], e_sw, e_main, e_band,
      e_band ? sw[15:14] : sw[18:17], e_en & sleep_pin_n, ~sw[22] | e_lock};
  endfunction

  task automatic reset_model();
    sw = '0;
    e_sw = '0;
    e_main = '0;
    e_band = 1'b0;
    e_en = 1'b0;
    e_lock = 1'b0;
  endtask
  // Update prediction; a word with the high address bit is ignored
  task automatic apply(input logic [WORD_W-1:0] w);
    if (w[23]) begin
      return;
    end
    if (w[0]) begin
      sw = w;
      e_en = w[21] & ~w[19];
      if (w[19])
        e_band = 1'b0;
    end else begin
      e_sw = w[7:1];
      e_main = w[18:8];
      e_band = w[22];
      e_en = w[21];
    end
  endtask

  task automatic chk(input logic [37:0] g, input logic [37:0] e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  // Inputs change a fixed 2 ns after the rising edge
  task automatic step();
    @(posedge ref_clk);
    #2;
  endtask
  task automatic do_word(input logic [WORD_W-1:0] w);
    step();
    rl_seen = 1'b0;
    in_seen = 1'b0;
    ssp_host_model_inst.send_word(w);
    apply(w);
    chk(got, pred());
    chk1(in_seen, ~w[23] & w[0] & w[19]);
    chk1(rl_seen, ~w[23] & sw[12]);
  endtask
  task automatic tick();
    step();
    compare_tick = 1'b1;
    repeat (3) step();
    compare_tick = 1'b0;
    repeat (3) step();
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Guard against a hang
  initial begin
    #1000000;
    miscompares++;
    close_out();
  end

  initial begin
    // Host keeps ratios legal and starts with an init write
    rows[0] = {sw_w(11'h280, 11'h041), 2'b10};
    rows[1] = {cw_w(1'b0, 1'b1, 11'h05B, 7'h24), 2'b11};
    rows[2] = {sw_w(11'h15F, 11'h7FF), 2'b10};
    rows[3] = {cw_w(1'b1, 1'b1, 11'h080, 7'h7F), 2'b11};
    rows[4] = {24'hAAAAAA, 2'b11};
    rows[5] = {24'hFFFFFF, 2'b11};
    rows[6] = {sw_w(11'h228, 11'h002), 2'b11};
    rows[7] = {cw_w(1'b0, 1'b1, 11'h7FF, 7'h00), 2'b11};
    rows[8] = {cw_w(1'b1, 1'b1, 11'h05B, 7'h24), 2'b00};
    rows[9] = {sw_w(11'h280, 11'h041), 2'b10};
    rows[10] = {cw_w(1'b0, 1'b1, 11'h05B, 7'h24), 2'b11};
    reset_model();
    repeat (20) step();
    rst_b = 1'b1;
    chk(got, pred());
    foreach (rows[i]) begin
      step();
      sleep_pin_n = rows[i].sleep_n;
      do_word(rows[i].word);
      chk1(synth_enable, rows[i].en);
      $display("row %0d done", i);
    end
    // Lock qualification boundary: 14 short periods, then the 15th
    do_word(sw_w(11'h600, 11'h041));
    repeat (14) tick();
    repeat (2) step();
    chk(got, pred());
    tick();
    repeat (2) step();
    e_lock = 1'b1;
    chk(got, pred());
    pump_pulse_long = 1'b1;
    repeat (6) step();
    e_lock = 1'b0;
    chk(got, pred());
    pump_pulse_long = 1'b0;
    $display("lock test done");
    // Reset in mid-run restores reset values
    rst_b = 1'b0;
    repeat (3) step();
    reset_model();
    chk(got, pred());
    rst_b = 1'b1;
    // Outputs keep reset values past the release, then programming works
    repeat (2) step();
    chk(got, pred());
    do_word(sw_w(11'h280, 11'h041));
    do_word(cw_w(1'b0, 1'b1, 11'h05B, 7'h24));
    chk1(synth_enable, 1'b1);
    $display("reset test done");
    close_out();
  end
endmodule
